// ==== verilog/tcc_map.svh ====
// offsets, field positions and counts of the trigger condition counter bank
// assumes byte addressing on the register port, one 32-bit word per register
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// register byte offsets
`define TCC_COMMAND_OFS 16'h0000
`define TCC_FLAGS_OFS 16'h0004
`define TCC_HOLD_BASE 16'h1000
`define TCC_HOLD_END 16'h18a0

// counter_command fields
`define TCC_CMD_CLEAR 0
`define TCC_CMD_LATCH 1
`define TCC_CMD_DONE 2

// counter_flags fields
`define TCC_FLG_READY 0
`define TCC_FLG_ERROR 1
`define TCC_FLG_OVERFLOW 2

// bank geometry
`define TCC_CNT_WIDTH 40
`define TCC_NUM_TRIG 64
`define TCC_NUM_MULTI 8
`define TCC_NUM_SINGLE 56
`define TCC_NUM_DET 16
`define TCC_NUM_CNT 276
`define TCC_NUM_HOLD 552

// counter index bases
`define TCC_IDX_PHYSICS_MATCH_COUNT 0
`define TCC_IDX_CLEAN 64
`define TCC_IDX_CLIVE 128
`define TCC_IDX_ISSUED 192
`define TCC_IDX_DET 256
`define TCC_IDX_DEAD 272
`define TCC_IDX_XING 273
`define TCC_IDX_TRIG 274
`define TCC_IDX_RESP 275

`endif

// ==== verilog/tcc_pkg.sv ====
// types shared by the counter bank and its counter cells
// assumes tcc_map.svh sizes; widths are written out to stay self-contained
package tcc_pkg;

    // per-crossing condition inputs from the trigger logic
    typedef struct packed {
        logic [7:0][3:0] compSat;
        logic [7:0][3:0] compEn;
        logic [63:0] trigEn;
        logic [55:0] singleSat;
        logic [63:0] contamEn;
        logic contamVeto;
        logic [63:0] liveOk;
        logic [63:0] prescaleOk;
        logic [15:0] detLive;
        logic tokenFifoEmpty;
        logic runEnable;
        logic xingTick;
        logic trigIssued;
        logic respIssued;
        logic [3:0] readoutMask;
    } tcc_cond_t;

    // register port request
    typedef struct packed {
        logic write;
        logic read;
        logic [15:0] addr;
        logic [31:0] wdata;
    } tcc_regreq_t;

    // external scaler words
    typedef struct packed {
        logic [15:0] physLo;
        logic [15:0] physHi;
        logic [23:0] aux;
    } tcc_scaler_t;

    // state of one counter cell
    typedef struct packed {
        logic [39:0] count;
    } tcc_cnt_state_t;

endpackage : tcc_pkg

// ==== verilog/tcc_event_counter.sv ====
// one 40-bit event counter cell of the bank
// assumes inc is already qualified by the crossing tick and all gates
`timescale 1ns/100ps
`include "tcc_map.svh"

module tcc_event_counter (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic inc,
    output logic [39:0] count,
    output logic wrap
);
    tcc_pkg::tcc_cnt_state_t state_r;
    tcc_pkg::tcc_cnt_state_t state_nxt;

    // add one per qualified crossing, clear wins
    always_comb begin
        state_nxt = state_r;
        if (clear) begin
            state_nxt.count = '0;
        end else if (inc) begin
            state_nxt.count = state_r.count + 40'h1;
        end
    end

    // count register; only reset and the clear command zero it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign count = state_r.count;
    // an increment from all ones rolls over; the bank flags it
    assign wrap = inc && !clear && (state_r.count == {`TCC_CNT_WIDTH{1'b1}});
endmodule : tcc_event_counter

// ==== verilog/tcc_counter_bank.sv ====
// trigger condition counter bank: 276 event counters, latch to holding
// registers, command/flags registers and the external scaler outputs
// assumes all inputs synchronous to sys_clk; xingTick is a one-cycle pulse
// per bunch crossing; one register request per cycle at most
//
// What this block does
// - every counter is forty bits binary
// - add one per qualified crossing, else hold
// - run gates all; fifo empty gates two
// - 64 physics counters count satisfied physics
// - clean means uncontaminated or contamination disabled
// - first eight triggers OR four enabled components
// - multi-component counters need some component enabled
// - issued count needs trigger and component enable
// - other 56 triggers: one always-enabled component
// - sixteen detector live counters
// - one counter of token-starved crossings
// - totals of crossings, triggers and response_total
// - capture runs alongside counting, no stall
// - readout never clears counters
// - each counter into two 32-bit holding words
// - command bits: clear, latch, reading done
// - latch captures all, then sets ready
// - done bit seen clears ready
// - latch while ready sets error flag
// - any counter overflow sets overflow flag
// - drive physics, live, veto, mask to scaler
`timescale 1ns/100ps
`include "tcc_map.svh"

module tcc_counter_bank (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire tcc_pkg::tcc_cond_t cond,
    input wire tcc_pkg::tcc_regreq_t regReq,
    output logic [31:0] regRdata,
    output logic regAck,
    output tcc_pkg::tcc_scaler_t scaler
);
    // flags, holds, readback and scaler state in one record; the counts stay in the cells
    typedef struct packed {
        logic doneBit;
        logic dataReady;
        logic errFlag;
        logic ovfFlag;
        logic [31:0] rdData;
        logic rdAck;
        tcc_pkg::tcc_scaler_t scaler;
        logic [`TCC_NUM_HOLD-1:0][31:0] hold;
    } tcc_bank_state_t;

    tcc_bank_state_t state_r;
    tcc_bank_state_t state_nxt;

    // per-counter increments, wraps and running values
    logic [`TCC_NUM_CNT-1:0] inc;
    logic [`TCC_NUM_CNT-1:0] wrap;
    logic [`TCC_NUM_CNT-1:0][39:0] count;

    // per-trigger conditions
    logic [63:0] physCond;
    logic [63:0] anyCompEn;
    logic [63:0] cleanCond;
    logic [63:0] cleanLiveCond;
    logic [63:0] issuedCond;

    // increment groups in counter order
    logic [63:0] physInc;
    logic [63:0] cleanInc;
    logic [63:0] cliveInc;
    logic [63:0] issuedInc;
    logic [15:0] detInc;
    logic deadInc;
    logic xingInc;
    logic trigInc;
    logic respInc;

    // crossing gates
    logic gateRun;
    logic gateToken;

    // register port decode
    logic cmdHit;
    logic flagsHit;
    logic cmdWrite;
    logic clearCmd;
    logic latchCmd;
    logic doneCmd;
    logic [15:0] holdOfs;
    logic [13:0] holdIdx;
    logic holdHit;

    // flag set and clear terms
    logic doneSet;
    logic doneClr;
    logic readySet;
    logic readyClr;
    logic errSet;
    logic errClr;
    logic ovfSet;
    logic ovfClr;

    // capture, readback and scaler words
    logic [`TCC_NUM_HOLD-1:0][31:0] snapWords;
    logic [31:0] cmdWord;
    logic [31:0] flagsWord;
    logic [31:0] holdWord;
    logic [15:0] physLoWord;
    logic [15:0] physHiWord;
    logic [23:0] auxWord;

    // register selects; any other read falls to the holding words, any other write is ignored
    assign cmdHit = (regReq.addr == `TCC_COMMAND_OFS);
    assign flagsHit = (regReq.addr == `TCC_FLAGS_OFS);

    // command decode; clear and latch act as one-cycle strobes
    assign cmdWrite = regReq.write && cmdHit;
    assign clearCmd = cmdWrite && regReq.wdata[`TCC_CMD_CLEAR];
    assign latchCmd = cmdWrite && regReq.wdata[`TCC_CMD_LATCH];
    assign doneCmd = cmdWrite && regReq.wdata[`TCC_CMD_DONE];

    // crossing gates shared by the whole bank
    assign gateRun = cond.xingTick && cond.runEnable;
    assign gateToken = gateRun && !cond.tokenFifoEmpty;

    // per-trigger conditions
    always_comb begin
        physCond = '0;
        anyCompEn = '0;
        cleanCond = '0;
        cleanLiveCond = '0;
        issuedCond = '0;
        // OR of enabled components only, so an idle component never counts
        for (int t = 0; t < `TCC_NUM_MULTI; t++) begin
            physCond[t] = |(cond.compSat[t] & cond.compEn[t]);
            anyCompEn[t] = |cond.compEn[t];
        end
        // separate loops keep every index in range at elaboration
        for (int t = `TCC_NUM_MULTI; t < `TCC_NUM_TRIG; t++) begin
            physCond[t] = cond.singleSat[t-`TCC_NUM_MULTI];
            anyCompEn[t] = 1'b1;
        end
        for (int t = 0; t < `TCC_NUM_TRIG; t++) begin
            cleanCond[t] = physCond[t] && anyCompEn[t]
                && (!cond.contamVeto || !cond.contamEn[t]);
            cleanLiveCond[t] = cleanCond[t] && cond.liveOk[t];
            issuedCond[t] = cleanLiveCond[t] && cond.prescaleOk[t]
                && cond.trigEn[t];
        end
    end

    // per-trigger increment groups; only the live and issued groups wait on tokens
    assign physInc = {64{gateRun}} & physCond & anyCompEn;
    assign cleanInc = {64{gateRun}} & cleanCond;
    assign cliveInc = {64{gateToken}} & cleanLiveCond;
    assign issuedInc = {64{gateToken}} & issuedCond;
    assign detInc = {16{gateRun}} & cond.detLive;

    // single global counters
    assign deadInc = gateRun && cond.tokenFifoEmpty;
    assign xingInc = gateRun;
    assign trigInc = gateRun && cond.trigIssued;
    assign respInc = gateRun && cond.respIssued;

    // increment requests, one per counter, in holding-register order
    always_comb begin
        inc = '0;
        // four per-trigger groups
        for (int t = 0; t < `TCC_NUM_TRIG; t++) begin
            inc[`TCC_IDX_PHYSICS_MATCH_COUNT + t] = physInc[t];
            inc[`TCC_IDX_CLEAN + t] = cleanInc[t];
            inc[`TCC_IDX_CLIVE + t] = cliveInc[t];
            inc[`TCC_IDX_ISSUED + t] = issuedInc[t];
        end
        // detectors, then the single counters
        for (int d = 0; d < `TCC_NUM_DET; d++) begin
            inc[`TCC_IDX_DET + d] = detInc[d];
        end
        inc[`TCC_IDX_DEAD] = deadInc;
        inc[`TCC_IDX_XING] = xingInc;
        inc[`TCC_IDX_TRIG] = trigInc;
        inc[`TCC_IDX_RESP] = respInc;
    end

    // the counters themselves; only reset and the clear command zero them
    for (genvar c = 0; c < `TCC_NUM_CNT; c++) begin : gCnt
        tcc_event_counter uCnt (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .clear(clearCmd),
            .inc(inc[c]),
            .count(count[c]),
            .wrap(wrap[c])
        );
    end

    // holding-register address decode
    assign holdOfs = regReq.addr - `TCC_HOLD_BASE;
    assign holdIdx = holdOfs[15:2];
    assign holdHit = (regReq.addr >= `TCC_HOLD_BASE) && (regReq.addr < `TCC_HOLD_END)
        && (regReq.addr[1:0] == 2'h0);

    // done is stored one cycle so the client can read it back
    assign doneSet = doneCmd;
    assign doneClr = state_r.doneBit;

    // a latch outranks a done that is still pending
    assign readySet = latchCmd;
    assign readyClr = state_r.doneBit;

    // relatching unread data loses it, hence the error
    assign errSet = latchCmd && state_r.dataReady;
    assign errClr = clearCmd;
    // wraps are already masked by clear inside each cell
    assign ovfSet = |wrap;
    assign ovfClr = clearCmd;

    // snapshot source: low word, then the top eight bits zero-extended
    always_comb begin
        for (int c = 0; c < `TCC_NUM_CNT; c++) begin
            snapWords[2*c] = count[c][31:0];
            snapWords[2*c+1] = {24'h000000, count[c][39:32]};
        end
    end

    // readback words; reserved bits read as zero
    always_comb begin
        cmdWord = 32'h00000000;
        cmdWord[`TCC_CMD_DONE] = state_r.doneBit;
        flagsWord = 32'h00000000;
        flagsWord[`TCC_FLG_READY] = state_r.dataReady;
        flagsWord[`TCC_FLG_ERROR] = state_r.errFlag;
        flagsWord[`TCC_FLG_OVERFLOW] = state_r.ovfFlag;
    end
    // misaligned or unmapped reads give zero
    assign holdWord = holdHit ? state_r.hold[holdIdx] : 32'h00000000;

    // scaler words straight from the live conditions
    assign physLoWord = physCond[15:0];
    assign physHiWord = physCond[31:16];
    assign auxWord = {cond.readoutMask, 3'h0, cond.contamVeto, cond.detLive};

    // flags, capture, readback and scaler words
    always_comb begin
        state_nxt = state_r;

        // done bit is kept one cycle only, whether or not ready clears
        if (doneSet) begin
            state_nxt.doneBit = 1'b1;
        end else if (doneClr) begin
            state_nxt.doneBit = 1'b0;
        end

        // latch sets ready; a new latch outranks a pending done
        if (readySet) begin
            state_nxt.dataReady = 1'b1;
        end else if (readyClr) begin
            state_nxt.dataReady = 1'b0;
        end

        // sticky error and overflow; a fresh event beats the clear
        if (errSet) begin
            state_nxt.errFlag = 1'b1;
        end else if (errClr) begin
            state_nxt.errFlag = 1'b0;
        end
        if (ovfSet) begin
            state_nxt.ovfFlag = 1'b1;
        end else if (ovfClr) begin
            state_nxt.ovfFlag = 1'b0;
        end

        // one-edge snapshot of every counter; counting carries on untouched
        if (latchCmd) begin
            state_nxt.hold = snapWords;
        end

        // readback never touches the counters, only the held copies
        state_nxt.rdAck = regReq.read;
        state_nxt.rdData = 32'h00000000;
        if (regReq.read) begin
            if (cmdHit) begin
                state_nxt.rdData = cmdWord;
            end else if (flagsHit) begin
                state_nxt.rdData = flagsWord;
            end else begin
                state_nxt.rdData = holdWord;
            end
        end

        // scaler bits follow the live conditions every cycle
        state_nxt.scaler.physLo = physLoWord;
        state_nxt.scaler.physHi = physHiWord;
        state_nxt.scaler.aux = auxWord;
    end

    // whole-record register; reset zeroes flags, holds and outputs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the record, so no decode glitch leaks out
    assign regRdata = state_r.rdData;
    assign regAck = state_r.rdAck;
    assign scaler = state_r.scaler;
endmodule : tcc_counter_bank

// ==== verification/tcc_counter_bank_props.sv ====
// checker of the counter bank register port, handshake flags and scaler outputs
// assumes it is bound to tcc_counter_bank and sees only its ports
`timescale 1ns/100ps
`include "tcc_map.svh"

module tcc_counter_bank_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire tcc_pkg::tcc_cond_t cond,
    input wire tcc_pkg::tcc_regreq_t regReq,
    input wire logic [31:0] regRdata,
    input wire logic regAck,
    input wire tcc_pkg::tcc_scaler_t scaler
);
    logic live_r;
    logic [31:0] physLow;

    // history is only trusted from the second edge after reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) live_r <= 1'b0;
        else live_r <= 1'b1;
    end

    // physics bits of the first 32 triggers, worked out independently
    always_comb begin
        for (int t = 0; t < 8; t++) physLow[t] = |(cond.compSat[t] & cond.compEn[t]);
        for (int t = 8; t < 32; t++) physLow[t] = cond.singleSat[t - 8];
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // command writes with one bit of interest and the flags poll
    sequence latchWr;
        regReq.write && regReq.addr == `TCC_COMMAND_OFS && regReq.wdata[2:0] == 3'h2;
    endsequence
    sequence doneWr;
        regReq.write && regReq.addr == `TCC_COMMAND_OFS && regReq.wdata[2:0] == 3'h4;
    endsequence
    sequence clearWr;
        regReq.write && regReq.addr == `TCC_COMMAND_OFS && regReq.wdata[2:0] == 3'h1;
    endsequence
    sequence flagsRd;
        !regReq.write ##1 regReq.read && !regReq.write && regReq.addr == `TCC_FLAGS_OFS;
    endsequence

    ready_after_latch_a: assert property (latchWr ##1 flagsRd |=> regRdata[0])
        else $error("ready flag not set after latch");
    error_on_relatch_a: assert property (latchWr ##2 latchWr ##1 flagsRd |=> regRdata[1])
        else $error("error flag not set on latch while ready");
    done_clears_a: assert property (doneWr ##1 flagsRd |=> !regRdata[0])
        else $error("ready flag not cleared by reading done");
    clear_drops_flags_a: assert property (clearWr ##1 flagsRd |=> regRdata[2:1] == 2'b00)
        else $error("error or overflow flag survived clear");
    read_answered_a: assert property (regReq.read |=> regAck)
        else $error("read not acknowledged next cycle");
    ack_has_cause_a: assert property (live_r && regAck |-> $past(regReq.read))
        else $error("ack without a read");
    high_word_a: assert property (regReq.read && regReq.addr >= `TCC_HOLD_BASE
        && regReq.addr < `TCC_HOLD_END && regReq.addr[2] |=> regRdata[31:8] == 24'h0)
        else $error("high holding word wider than 8 bits");
    scaler_physics_match_count_a: assert property (
        live_r |-> {scaler.physHi, scaler.physLo} == $past(physLow))
        else $error("scaler physics bits wrong");
    scaler_aux_a: assert property (
        live_r |-> scaler.aux == {$past(cond.readoutMask), 3'h0,
        $past(cond.contamVeto), $past(cond.detLive)})
        else $error("scaler status word wrong");
endmodule : tcc_counter_bank_props

// ==== verification/tcc_vme_client.sv ====
// client model of the register port: writes, reads and the latch readout handshake
// assumes the bank answers a read with regAck and data one cycle after taking it
`timescale 1ns/100ps
`include "tcc_map.svh"

module tcc_vme_client (
    input wire logic sys_clk,
    output tcc_pkg::tcc_regreq_t regReq,
    input wire logic [31:0] regRdata,
    input wire logic regAck
);
    logic [31:0] holdW [552];
    logic readyMissed = 1'b0;

    // idle bus from time zero
    initial regReq = '0;

    // one write, dropped after the taking edge
    task wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        regReq = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        regReq.write = 1'b0;
        regReq.wdata = ~d; // stale data never looks valid
    endtask : wr

    // one read; a missing ack yields a value no high holding word can hold
    task rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge sys_clk);
        regReq.read = 1'b1;
        regReq.addr = a;
        @(negedge sys_clk);
        regReq.read = 1'b0;
        d = regAck ? regRdata : 32'hdead_beef;
    endtask : rd

    // latch, poll ready, read all holding words, then report done
    task readout;
        logic [31:0] d;
        d = '0;
        wr(`TCC_COMMAND_OFS, 32'h2);
        for (int n = 0; n < 20 && !d[0]; n++) rd(`TCC_FLAGS_OFS, d);
        readyMissed = !d[0]; // poll limit ran out; the bench counts it
        for (int j = 0; j < 552; j++) rd(`TCC_HOLD_BASE + 16'(4 * j), holdW[j]);
        wr(`TCC_COMMAND_OFS, 32'h4);
    endtask : readout
endmodule : tcc_vme_client

// ==== verification/tcc_counter_bank_tb.sv ====
// self-checking bench: crossings with varied conditions, readouts, flags, clear
// assumes tcc_counter_bank, the client model and the checker compile beside it
`timescale 1ns/100ps
`include "tcc_map.svh"

module tcc_counter_bank_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    tcc_pkg::tcc_cond_t c = '0;
    tcc_pkg::tcc_regreq_t regReq;
    tcc_pkg::tcc_scaler_t scaler;
    logic [31:0] regRdata;
    logic [31:0] d;
    logic regAck;
    logic [39:0] expc [276];
    int errTotal = 0;
    int testsRun = 0;

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    tcc_counter_bank tcc_counter_bank_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cond(c),
        .regReq(regReq), .regRdata(regRdata), .regAck(regAck), .scaler(scaler));
    tcc_vme_client tcc_vme_client_inst (.sys_clk(sys_clk), .regReq(regReq),
        .regRdata(regRdata), .regAck(regAck));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task giveVerdict;
        if (errTotal == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : giveVerdict

    // one crossing slot; pattern fixed by i, expected counts updated alongside
    task tick(input int i, input bit x);
        logic [63:0] p;
        logic [63:0] ph;
        logic [63:0] cl;
        logic [63:0] lv;
        logic [275:0] hit;
        p = 64'h9e37_79b9_7f4a_7c15 * (i + 1);
        @(negedge sys_clk);
        c = '{compSat: p[31:0], compEn: (i == 3) ? 32'h0 : p[63:32], trigEn: ~p ^ {p[31:0],
            p[63:32]}, singleSat: p[55:0] ^ p[63:8], contamEn: {p[31:0], p[63:32]},
            contamVeto: i[0], liveOk: ~p, prescaleOk: p ^ 64'h00ff_00ff_00ff_00ff,
            detLive: p[40:25], tokenFifoEmpty: (i % 3 == 0), runEnable: (i != 5),
            xingTick: x, trigIssued: p[9], respIssued: p[11], readoutMask: p[3:0]};
        for (int t = 0; t < 8; t++) ph[t] = |(c.compSat[t] & c.compEn[t]);
        for (int t = 8; t < 64; t++) ph[t] = c.singleSat[t - 8];
        cl = ph & ~({64{c.contamVeto}} & c.contamEn);
        lv = cl & c.liveOk & {64{~c.tokenFifoEmpty}};
        hit = {c.respIssued, c.trigIssued, 1'b1, c.tokenFifoEmpty, c.detLive,
            lv & c.trigEn & c.prescaleOk, lv, cl, ph};
        for (int k = 0; k < 276; k++) expc[k] += 40'(hit[k] & x & c.runEnable);
        @(negedge sys_clk);
        c.xingTick = 1'b0;
    endtask : tick

    // holding words against expected running totals
    task cmpAll;
        chk({31'h0, tcc_vme_client_inst.readyMissed}, 32'h0);
        for (int k = 0; k < 276; k++) begin
            chk(tcc_vme_client_inst.holdW[2 * k], expc[k][31:0]);
            chk(tcc_vme_client_inst.holdW[2 * k + 1], {24'h0, expc[k][39:32]});
        end
    endtask : cmpAll

    // watchdog well beyond the expected run of a few thousand cycles
    initial begin
        #200000;
        errTotal++;
        giveVerdict();
    end

    // main sequence
    initial begin
        for (int k = 0; k < 276; k++) expc[k] = '0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 14; i++) tick(i, i != 7);
        tcc_vme_client_inst.readout();
        cmpAll();
        for (int i = 14; i < 20; i++) tick(i, 1'b1);
        tcc_vme_client_inst.readout();
        cmpAll();
        tcc_vme_client_inst.wr(`TCC_COMMAND_OFS, 32'h2);
        tcc_vme_client_inst.wr(`TCC_COMMAND_OFS, 32'h2);
        tcc_vme_client_inst.rd(`TCC_FLAGS_OFS, d);
        chk(d, 32'h3);
        tcc_vme_client_inst.wr(`TCC_COMMAND_OFS, 32'h4);
        tcc_vme_client_inst.rd(`TCC_FLAGS_OFS, d);
        chk(d, 32'h2);
        tcc_vme_client_inst.rd(`TCC_COMMAND_OFS, d);
        chk(d, 32'h0);
        tcc_vme_client_inst.wr(`TCC_COMMAND_OFS, 32'h1);
        tcc_vme_client_inst.rd(`TCC_FLAGS_OFS, d);
        chk(d, 32'h0);
        for (int k = 0; k < 276; k++) expc[k] = '0;
        tick(20, 1'b1);
        tcc_vme_client_inst.readout();
        cmpAll();
        // unmapped read answers zero; flags ignore writes
        tcc_vme_client_inst.rd(16'h0100, d);
        chk(d, 32'h0);
        tcc_vme_client_inst.wr(`TCC_FLAGS_OFS, 32'h7);
        tcc_vme_client_inst.rd(`TCC_FLAGS_OFS, d);
        chk(d, 32'h0);
        giveVerdict();
    end
endmodule : tcc_counter_bank_tb

bind tcc_counter_bank tcc_counter_bank_props tcc_counter_bank_props_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .cond(cond), .regReq(regReq), .regRdata(regRdata), .regAck(regAck),
    .scaler(scaler));
